/* File: src/mcds_defs.svh */
// Constant definitions for the microcoded datapath sequencer
`ifndef MCDS_DEFS_SVH
`define MCDS_DEFS_SVH

// ----------------------------------------------------------------
// Microinstruction fields
// ----------------------------------------------------------------
`define MCDS_OP_HI      15
`define MCDS_OP_LO      13
`define MCDS_BAB_HI     12
`define MCDS_BAB_LO     11
`define MCDS_DST_HI     10
`define MCDS_DST_LO     8
`define MCDS_IN_HI      7
`define MCDS_IN_LO      4
`define MCDS_OUT_HI     3
`define MCDS_OUT_LO     0
`define MCDS_FN_HI      7
`define MCDS_FN_LO      4
`define MCDS_BIT_IN_SEL 7
`define MCDS_IMM_HI     7
`define MCDS_IMM_LO     0

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define MCDS_OP_MOV_I   3'h0
`define MCDS_OP_MOV_IB  3'h1
`define MCDS_OP_MOV_MEM 3'h2
`define MCDS_OP_MOV_BRG 3'h3
`define MCDS_OP_MOV_IBA 3'h5
`define MCDS_OP_BR_I    3'h4
`define MCDS_OP_BR_MEM  3'h6
`define MCDS_OP_BR_BRG  3'h7

// ----------------------------------------------------------------
// Destination codes
// ----------------------------------------------------------------
`define MCDS_DST_NONE   3'h0
`define MCDS_DST_OUT    3'h1
`define MCDS_DST_OUTA   3'h2
`define MCDS_DST_SPBRG  3'h3
`define MCDS_DST_SP     3'h4
`define MCDS_DST_MEM    3'h5
`define MCDS_DST_BRG    3'h6
`define MCDS_DST_BRGSH  3'h7

// ----------------------------------------------------------------
// Address register function field
// ----------------------------------------------------------------
`define MCDS_MFF_HOLD   2'h0
`define MCDS_MFF_LOAD   2'h1
`define MCDS_MFF_INC    2'h2

// ----------------------------------------------------------------
// Operand selector codes
// ----------------------------------------------------------------
`define MCDS_SEL_CS     3'h0
`define MCDS_SEL_IBUS   3'h1
`define MCDS_SEL_MEM    3'h2
`define MCDS_SEL_BRG    3'h3
`define MCDS_SEL_EVEN   3'h4
`define MCDS_SEL_ODD    3'h5
`define MCDS_SEL_XFER   3'h6
`define MCDS_SEL_MISC   3'h7

// ----------------------------------------------------------------
// Branch register mode lines {s1,s0}
// ----------------------------------------------------------------
`define MCDS_BR_HOLD    2'h0
`define MCDS_BR_SHR     2'h1
`define MCDS_BR_LOAD    2'h3

// ----------------------------------------------------------------
// Misc constants
// ----------------------------------------------------------------
`define MCDS_MAINT_SEL  3'h6
`define MCDS_PHASE_LAST 2'h3
`define MCDS_ZERO8      8'h00
`define MCDS_ZERO10     10'h000
`define MCDS_ONE8       8'h01
`define MCDS_ONE10      10'h001
`define MCDS_ZERO4      4'h0
`define MCDS_ZERO16     16'h0000
`define MCDS_PC_TOP     9
`define MCDS_PC_HALF_HI 8

`endif

/* File: src/mcds_pkg.sv */
// Types shared by the microcoded datapath sequencer
package mcds_pkg;

   // Decoded destination control word
   typedef struct packed {
      logic       addr_reg_load_n;
      logic       addr_reg_increment_n;
      logic [1:0] brg_mode;
      logic       wr_mem;
      logic       wr_sp;
      logic       wr_sp_addr;
      logic       wr_out_alt;
      logic       wr_out;
   } mcds_destination_field_t;

   // Host write of a control register
   typedef struct packed {
      logic        valid;
      logic [2:0]  sel;
      logic [15:0] data;
   } mcds_host_wr_t;

   // Timing phase states, Gray ordered
   typedef enum logic [1:0] {
      MCDS_PH_FETCH = 2'b00,
      MCDS_PH_DEC   = 2'b01,
      MCDS_PH_EXEC  = 2'b11,
      MCDS_PH_LATE  = 2'b10
   } mcds_phase_t;

endpackage

/* File: src/mcds_sequencer.sv */
// Microcoded datapath sequencer: control store, counter, registers, operand path
// Notes on behaviour
// - Operation code sits in microinstruction bits 15..13 and picks source form.
// - Immediate move sends bits 7..0 to destination named by bits 10..8.
// - Input-bus move reads one of sixteen input bytes chosen by bits 7..4.
// - Output, alternate output and scratch pad targets use bits 3..0 as position.
// - Code 101 acts as input-bus move but reads the alternate input block.
// - Memory move runs ALU on working memory byte and scratch pad entry bits 3..0, or entry 0 for output targets.
// - Branch-register move runs ALU on branch register and addressed scratch pad.
// - Counter loads from buffered result when selector low, else increments.
// - Branch target: low byte buffered result, top bits microinstruction 12 and 11.
// - Bits 10..8 pick branch condition; selector disabled on every move.
// - Right shift rotates bit 0 through ALU into result, then into bit 7.
// - Branch register lines: 11 load, 01 shift right, 10 unused, 00 hold.
// - Branch register clocks at end of late phase during moves.
// - Working memory has 256 bytes addressed by eight-bit address register.
// - Address register loads from result or increments at late phase end in moves.
// - Destination ROM decodes bits 12..8 into register and write controls.
// - Working memory written at address register with result data.
// - Operand selector picks B input from eight sources by three decode bits.
// - Source ROM has 32 entries addressed by bits 15..13, 4 and 7.
// - Control store holds 1024 words; counter top bit picks the half.
// - Maintenance word captures host data when control register 6 is written.
// - Maintenance word replaces control store only while enable bit set.
`timescale 1ns/1ps
`default_nettype none
`include "mcds_defs.svh"

module mcds_sequencer
   import mcds_pkg::*;
#(
   parameter int CS_DEPTH = 1024,
   parameter int WM_DEPTH = 256
) (
   // Clock and reset
   input  wire  logic                clk,
   input  wire  logic                srst,
   // Control store loading port
   input  wire  logic                cs_wr,
   input  wire  logic [9:0]          cs_wr_addr,
   input  wire  logic [15:0]         cs_wr_data,
   // Host maintenance access
   input  wire  mcds_host_wr_t       host_wr,
   input  wire  logic                maint_instr_en,
   // Data inputs
   input  wire  logic [127:0]        ibus_in,
   input  wire  logic [127:0]        ibus_alt_in,
   input  wire  logic [7:0]          bport_even,
   input  wire  logic [7:0]          bport_odd,
   input  wire  logic [7:0]          xfer_ctl,
   input  wire  logic [7:0]          misc_reg,
   input  wire  logic [7:0]          branch_cond,
   // ALU function result from the outside arithmetic unit
   input  wire  logic [7:0]          alu_result,
   // ALU operands and function to the arithmetic unit
   output logic [7:0]                alu_a_r,
   output logic [7:0]                alu_b_r,
   output logic [3:0]                alu_fn_r,
   // Outputs to bus blocks
   output logic                      out_wr_r,
   output logic                      out_alt_wr_r,
   output logic [3:0]                out_pos_r,
   output logic [7:0]                out_data_r,
   // State visible outside
   output logic [9:0]                pc_r,
   output logic [7:0]                memory_address_register_r,
   output logic [7:0]                branch_register_r,
   output logic [7:0]                buffered_alu_result_r,
   output logic [15:0]               microinstr_r,
   output logic                      late_timing_phase_r
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (CS_DEPTH != 1024) $error("CS_DEPTH must be 1024");
   if (WM_DEPTH != 256) $error("WM_DEPTH must be 256");

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   // Destination decode, addressed by {mff, destination_field}
   function automatic mcds_destination_field_t destination_field_decode(input logic [4:0] a);
      mcds_destination_field_t d;
      d = '0;
      d.addr_reg_load_n      = (a[4:3] != `MCDS_MFF_LOAD);
      d.addr_reg_increment_n = (a[4:3] != `MCDS_MFF_INC);
      d.brg_mode   = (a[2:0] == `MCDS_DST_BRG || a[2:0] == `MCDS_DST_SPBRG) ?
                     `MCDS_BR_LOAD :
                     (a[2:0] == `MCDS_DST_BRGSH) ? `MCDS_BR_SHR : `MCDS_BR_HOLD;
      d.wr_mem     = (a[2:0] == `MCDS_DST_MEM);
      d.wr_sp      = (a[2:0] == `MCDS_DST_SP || a[2:0] == `MCDS_DST_SPBRG);
      d.wr_sp_addr = (a[2:0] == `MCDS_DST_OUT || a[2:0] == `MCDS_DST_OUTA);
      d.wr_out_alt = (a[2:0] == `MCDS_DST_OUTA);
      d.wr_out     = (a[2:0] == `MCDS_DST_OUT);
      return d;
   endfunction

   // Source decode, addressed by {op, bit4, bit7}; low 3 bits select operand
   function automatic logic [2:0] src_decode(input logic [4:0] a);
      logic [2:0] s;
      s = `MCDS_SEL_CS;
      case (a[4:2])
         `MCDS_OP_MOV_I, `MCDS_OP_BR_I: s = `MCDS_SEL_CS;
         `MCDS_OP_MOV_IB, `MCDS_OP_MOV_IBA: s = `MCDS_SEL_IBUS;
         `MCDS_OP_MOV_MEM, `MCDS_OP_BR_MEM: s = `MCDS_SEL_MEM;
         `MCDS_OP_MOV_BRG, `MCDS_OP_BR_BRG: s = `MCDS_SEL_BRG;
         default: s = `MCDS_SEL_CS;
      endcase
      return s;
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0]  cs_lo_mem [CS_DEPTH/2];
   logic [15:0]  cs_hi_mem [CS_DEPTH/2];
   logic [7:0]   wm_mem [WM_DEPTH];
   logic [7:0]   sp_mem [16];
   logic [15:0]  maint_word_r;
   mcds_phase_t  phase_r;
   mcds_phase_t  phase_nxt;

   // ----------------------------------------------------------------
   // Current microinstruction selection
   // ----------------------------------------------------------------
   logic [15:0]  cs_word;
   logic         cs_drive;
   logic         mw_drive;
   logic [15:0]  uinstr;
   assign cs_drive = ~maint_instr_en;
   assign mw_drive = maint_instr_en;
   // Counter top bit picks the half of the control store
   assign cs_word  = pc_r[`MCDS_PC_TOP] ? cs_hi_mem[pc_r[`MCDS_PC_HALF_HI:0]] :
                                          cs_lo_mem[pc_r[`MCDS_PC_HALF_HI:0]];
   assign uinstr   = ({16{cs_drive}} & cs_word) | ({16{mw_drive}} & maint_word_r);

   // Field extraction
   logic [2:0]   op;
   logic [2:0]   dst;
   logic [3:0]   in_pos;
   logic [3:0]   out_pos;
   logic         is_move;
   mcds_destination_field_t   dctl;
   logic [2:0]   opsel;
   assign op      = microinstr_r[`MCDS_OP_HI:`MCDS_OP_LO];
   assign dst     = microinstr_r[`MCDS_DST_HI:`MCDS_DST_LO];
   assign in_pos  = microinstr_r[`MCDS_IN_HI:`MCDS_IN_LO];
   assign out_pos = microinstr_r[`MCDS_OUT_HI:`MCDS_OUT_LO];
   assign is_move = (op != `MCDS_OP_BR_I) && (op != `MCDS_OP_BR_MEM) &&
                    (op != `MCDS_OP_BR_BRG);
   assign dctl    = destination_field_decode(microinstr_r[`MCDS_BAB_HI:`MCDS_DST_LO]);
   assign opsel   = src_decode({op, microinstr_r[`MCDS_IN_LO],
                                microinstr_r[`MCDS_BIT_IN_SEL]});

   // ----------------------------------------------------------------
   // Operand selector and A side
   // ----------------------------------------------------------------
   logic [7:0]   ibus_byte;
   logic [7:0]   b_sel;
   logic [3:0]   sp_addr;
   // Alternate input block for code 101
   assign ibus_byte = (op == `MCDS_OP_MOV_IBA) ? ibus_alt_in[in_pos*8 +: 8] :
                                                 ibus_in[in_pos*8 +: 8];
   always_comb begin
      case (opsel)
         `MCDS_SEL_CS:   b_sel = microinstr_r[`MCDS_IMM_HI:`MCDS_IMM_LO];
         `MCDS_SEL_IBUS: b_sel = ibus_byte;
         `MCDS_SEL_MEM:  b_sel = wm_mem[memory_address_register_r];
         `MCDS_SEL_BRG:  b_sel = branch_register_r;
         `MCDS_SEL_EVEN: b_sel = bport_even;
         `MCDS_SEL_ODD:  b_sel = bport_odd;
         `MCDS_SEL_XFER: b_sel = xfer_ctl;
         default:        b_sel = misc_reg;
      endcase
   end
   // Output destinations present scratch pad 0 to the A side
   assign sp_addr = dctl.wr_sp_addr ? `MCDS_ZERO4 : out_pos;

   // ----------------------------------------------------------------
   // Timing phase sequencer
   // ----------------------------------------------------------------
   always_comb begin
      case (phase_r)
         MCDS_PH_FETCH: phase_nxt = MCDS_PH_DEC;
         MCDS_PH_DEC:   phase_nxt = MCDS_PH_EXEC;
         MCDS_PH_EXEC:  phase_nxt = MCDS_PH_LATE;
         default:       phase_nxt = MCDS_PH_FETCH;
      endcase
   end

   logic         late_end;
   assign late_end = (phase_r == MCDS_PH_LATE);

   always_ff @(posedge clk) begin
      if (srst) begin
         phase_r             <= MCDS_PH_FETCH;
         late_timing_phase_r <= 1'b0;
      end else begin
         phase_r             <= phase_nxt;
         late_timing_phase_r <= (phase_nxt == MCDS_PH_LATE);
      end
   end

   // Fetch the microinstruction at the start of each cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         microinstr_r <= `MCDS_ZERO16;
      end else if (phase_r == MCDS_PH_FETCH) begin
         microinstr_r <= uinstr;
      end
   end

   // Present operands, then buffer the ALU result
   always_ff @(posedge clk) begin
      if (srst) begin
         alu_a_r               <= `MCDS_ZERO8;
         alu_b_r               <= `MCDS_ZERO8;
         alu_fn_r              <= `MCDS_ZERO4;
         buffered_alu_result_r <= `MCDS_ZERO8;
      end else if (phase_r == MCDS_PH_DEC) begin
         alu_a_r  <= sp_mem[sp_addr];
         alu_b_r  <= b_sel;
         alu_fn_r <= microinstr_r[`MCDS_FN_HI:`MCDS_FN_LO];
      end else if (phase_r == MCDS_PH_EXEC) begin
         buffered_alu_result_r <= alu_result;
      end
   end

   // ----------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------
   logic         bmux_out;
   // Selector forced high on moves so the counter only increments
   assign bmux_out = is_move ? 1'b1 : branch_cond[dst];
   always_ff @(posedge clk) begin
      if (srst) begin
         pc_r <= `MCDS_ZERO10;
      end else if (late_end) begin
         if (!bmux_out) begin
            pc_r <= {microinstr_r[`MCDS_BAB_HI:`MCDS_BAB_LO],
                     buffered_alu_result_r};
         end else begin
            pc_r <= pc_r + `MCDS_ONE10;
         end
      end
   end

   // ----------------------------------------------------------------
   // Branch register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         branch_register_r <= `MCDS_ZERO8;
      end else if (late_end && is_move) begin
         case (dctl.brg_mode)
            `MCDS_BR_LOAD: branch_register_r <= buffered_alu_result_r;
            `MCDS_BR_SHR:  branch_register_r <= {buffered_alu_result_r[0],
                                                 branch_register_r[7:1]};
            default:       branch_register_r <= branch_register_r;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Address register and working memory
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         memory_address_register_r <= `MCDS_ZERO8;
      end else if (late_end && is_move) begin
         if (!dctl.addr_reg_load_n) begin
            memory_address_register_r <= buffered_alu_result_r;
         end else if (!dctl.addr_reg_increment_n) begin
            memory_address_register_r <= memory_address_register_r + `MCDS_ONE8;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (late_end && is_move && dctl.wr_mem) begin
         wm_mem[memory_address_register_r] <= buffered_alu_result_r;
      end
   end

   // Scratch pad write from the buffered result
   always_ff @(posedge clk) begin
      if (late_end && is_move && dctl.wr_sp) begin
         sp_mem[out_pos] <= buffered_alu_result_r;
      end
   end

   // Output bus strobes
   always_ff @(posedge clk) begin
      if (srst) begin
         out_wr_r     <= 1'b0;
         out_alt_wr_r <= 1'b0;
         out_pos_r    <= `MCDS_ZERO4;
         out_data_r   <= `MCDS_ZERO8;
      end else begin
         out_wr_r     <= late_end && is_move && dctl.wr_out;
         out_alt_wr_r <= late_end && is_move && dctl.wr_out_alt;
         out_pos_r    <= out_pos;
         out_data_r   <= buffered_alu_result_r;
      end
   end

   // Control store loading
   always_ff @(posedge clk) begin
      if (cs_wr) begin
         if (cs_wr_addr[`MCDS_PC_TOP]) begin
            cs_hi_mem[cs_wr_addr[`MCDS_PC_HALF_HI:0]] <= cs_wr_data;
         end else begin
            cs_lo_mem[cs_wr_addr[`MCDS_PC_HALF_HI:0]] <= cs_wr_data;
         end
      end
   end

   // Maintenance word capture
   always_ff @(posedge clk) begin
      if (srst) begin
         maint_word_r <= `MCDS_ZERO16;
      end else if (host_wr.valid && host_wr.sel == `MCDS_MAINT_SEL) begin
         maint_word_r <= host_wr.data;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_pc_move_inc: assert property (@(posedge clk) disable iff (srst)
      late_end && is_move |=> pc_r == $past(pc_r) + `MCDS_ONE10)
      else $error("counter did not increment on move");
   chk_pc_branch: assert property (@(posedge clk) disable iff (srst)
      late_end && !bmux_out |=> pc_r == {$past(microinstr_r[`MCDS_BAB_HI:`MCDS_BAB_LO]),
                                         $past(buffered_alu_result_r)})
      else $error("branch target wrong");
   chk_brg_shift: assert property (@(posedge clk) disable iff (srst)
      late_end && is_move && dctl.brg_mode == `MCDS_BR_SHR |=>
      branch_register_r[7] == $past(buffered_alu_result_r[0]))
      else $error("shift did not rotate result bit");
   chk_brg_hold: assert property (@(posedge clk) disable iff (srst)
      !(late_end && is_move) |=> $stable(branch_register_r))
      else $error("branch register changed outside move end");
   chk_mar_load: assert property (@(posedge clk) disable iff (srst)
      late_end && is_move && !dctl.addr_reg_load_n |=>
      memory_address_register_r == $past(buffered_alu_result_r))
      else $error("address register load missed");
   chk_maint_cap: assert property (@(posedge clk) disable iff (srst)
      host_wr.valid && host_wr.sel == `MCDS_MAINT_SEL |=> maint_word_r == $past(host_wr.data))
      else $error("maintenance word not captured");
   chk_maint_sel: assert property (@(posedge clk) disable iff (srst)
      phase_r == MCDS_PH_FETCH && maint_instr_en |=> microinstr_r == $past(maint_word_r))
      else $error("maintenance word not used");
   chk_one_driver: assert property (@(posedge clk) disable iff (srst)
      phase_r == MCDS_PH_FETCH |-> uinstr == (maint_instr_en ? maint_word_r : cs_word))
      else $error("microinstruction not from a single source");
   chk_imm_operand: assert property (@(posedge clk) disable iff (srst)
      phase_r == MCDS_PH_DEC && op == `MCDS_OP_MOV_I |=>
      alu_b_r == $past(microinstr_r[`MCDS_IMM_HI:`MCDS_IMM_LO]))
      else $error("immediate operand wrong");

endmodule
`default_nettype wire

/* File: verif/mcds_host_model.sv */
// Host model that loads the maintenance word over the system bus
`timescale 1ns/1ps
`default_nettype none
module mcds_host_model
   import mcds_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Control register write
   output var mcds_host_wr_t host_wr
);
   initial host_wr = '0;
   // One-cycle register write, data held with the strobe
   task automatic write(input logic [2:0] sel, input logic [15:0] data);
      @(posedge clk);
      host_wr <= '{valid: 1'b1, sel: sel, data: data};
      @(posedge clk);
      host_wr <= '0;
   endtask
endmodule
`default_nettype wire

/* File: verif/microcoded_datapath_sequencer_tb.sv */
// Self-checking bench for the microcoded datapath sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); n_mismatch++; end end
module microcoded_datapath_sequencer_tb
   import mcds_pkg::*;
;
   logic clk, srst, cs_wr, maint_instr_en;
   logic [9:0] cs_wr_addr, pc_r;
   logic [15:0] cs_wr_data, microinstr_r;
   logic [127:0] ibus_in, ibus_alt_in;
   logic [7:0] branch_cond, alu_result, alu_a_r, alu_b_r, out_data_r, memory_address_register, branch_register, buffered_alu_result;
   logic [3:0] alu_fn_r, out_pos_r;
   logic out_wr_r, out_alt_wr_r, late_timing_phase_r;
   mcds_host_wr_t host_wr;
   int n_mismatch, n_checks, cycles;
   logic [15:0] prog [0:8] = '{16'h06A5, 16'h0833, 16'h155A, 16'h0833, 16'h4690,
                               16'h2139, 16'hA2C2, 16'h6790, 16'h9340};

   // Outside arithmetic unit modelled as select-B
   assign alu_result = alu_b_r;

   mcds_host_model host (.clk(clk), .host_wr(host_wr));

   mcds_sequencer dut (.clk(clk), .srst(srst), .cs_wr(cs_wr), .cs_wr_addr(cs_wr_addr),
      .cs_wr_data(cs_wr_data), .host_wr(host_wr), .maint_instr_en(maint_instr_en),
      .ibus_in(ibus_in), .ibus_alt_in(ibus_alt_in), .bport_even(8'h4e), .bport_odd(8'h4f),
      .xfer_ctl(8'h66), .misc_reg(8'h77), .branch_cond(branch_cond),
      .alu_result(alu_result), .alu_a_r(alu_a_r), .alu_b_r(alu_b_r), .alu_fn_r(alu_fn_r),
      .out_wr_r(out_wr_r), .out_alt_wr_r(out_alt_wr_r), .out_pos_r(out_pos_r),
      .out_data_r(out_data_r), .pc_r(pc_r), .memory_address_register_r(memory_address_register),
      .branch_register_r(branch_register), .buffered_alu_result_r(buffered_alu_result), .microinstr_r(microinstr_r),
      .late_timing_phase_r(late_timing_phase_r));

   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Control store write while reset is held
   task automatic load(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      cs_wr <= 1'b1;
      cs_wr_addr <= a;
      cs_wr_data <= d;
   endtask

   // Run one microcycle from mid-fetch to mid-fetch of the next
   task automatic step(input logic [7:0] cond, input logic men);
      int n;
      @(posedge clk);
      branch_cond <= cond;
      maint_instr_en <= men;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (late_timing_phase_r !== 1'b1 && n < 8);
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic t_imm();
      step(8'h00, 1'b0);
      `CHK(microinstr_r, 16'h06A5)
      `CHK(branch_register, 8'hA5)
      `CHK(pc_r, 10'h001)
      $display("test imm done");
   endtask

   task automatic t_mar_mem();
      step(8'h00, 1'b0);
      `CHK(memory_address_register, 8'h33)
      step(8'h00, 1'b0);
      `CHK(memory_address_register, 8'h34)
      step(8'h00, 1'b0);
      step(8'h00, 1'b0);
      `CHK(branch_register, 8'h5A)
      `CHK(alu_fn_r, 4'h9)
      $display("test mar_mem done");
   endtask

   task automatic t_ibus();
      step(8'h00, 1'b0);
      `CHK(out_wr_r, 1'b1)
      `CHK(out_pos_r, 4'h9)
      `CHK(out_data_r, 8'h83)
      step(8'h00, 1'b0);
      `CHK(out_alt_wr_r, 1'b1)
      `CHK(out_wr_r, 1'b0)
      `CHK(out_data_r, 8'hCC)
      `CHK(out_pos_r, 4'h2)
      $display("test ibus done");
   endtask

   task automatic t_shift();
      step(8'h00, 1'b0);
      `CHK(branch_register, 8'h2D)
      $display("test shift done");
   endtask

   task automatic t_branch();
      step(8'hF6, 1'b0);
      `CHK(pc_r, 10'h240)
      `CHK(branch_register, 8'h2D)
      `CHK(memory_address_register, 8'h33)
      step(8'hF6, 1'b1);
      `CHK(microinstr_r, 16'h8100)
      `CHK(pc_r, 10'h241)
      $display("test branch done");
   endtask

   task automatic t_maint();
      step(8'hF6, 1'b1);
      `CHK(microinstr_r, 16'h06C3)
      `CHK(branch_register, 8'hC3)
      `CHK(pc_r, 10'h242)
      $display("test maint done");
   endtask

   // Enable still set at this fetch, then scratch pad write and A-side read
   task automatic t_scratch();
      step(8'hF6, 1'b0);
      `CHK(microinstr_r, 16'h06C3)
      `CHK(pc_r, 10'h243)
      step(8'hF6, 1'b0);
      `CHK(microinstr_r, 16'h04A5)
      `CHK(branch_register, 8'hC3)
      step(8'hF6, 1'b0);
      `CHK(alu_a_r, 8'hA5)
      `CHK(alu_b_r, 8'hC3)
      `CHK(buffered_alu_result, 8'hC3)
      `CHK(late_timing_phase_r, 1'b0)
      $display("test scratch done");
   endtask

   // Main sequence
   initial begin
      srst = 1'b1;
      cs_wr = 1'b0;
      cs_wr_addr = 10'h000;
      cs_wr_data = 16'h0000;
      maint_instr_en = 1'b0;
      branch_cond = 8'h00;
      n_mismatch = 0;
      n_checks = 0;
      cycles = 0;
      for (int i = 0; i < 16; i++) begin
         ibus_in[8*i +: 8] = 8'h80 + 8'(i);
         ibus_alt_in[8*i +: 8] = 8'hC0 + 8'(i);
      end
      for (int i = 0; i < 9; i++)
         load(10'(i), prog[i]);
      load(10'h240, 16'h8100);
      load(10'h241, 16'h0611);
      load(10'h243, 16'h04A5);
      load(10'h244, 16'h6695);
      @(posedge clk);
      cs_wr <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(pc_r, 10'h000)
      srst <= 1'b0;
      fork
         begin
            host.write(3'h6, 16'h06C3);
            host.write(3'h5, 16'h06FF);
         end
      join_none
      @(negedge clk);
      t_imm();
      t_mar_mem();
      t_ibus();
      t_shift();
      t_branch();
      t_maint();
      t_scratch();
      test_done();
   end
endmodule
`default_nettype wire
